// [test/cbfls_core_tb.sv]
// self-checking bench for the core slice
`include "cbfls_consts.svh"
module cbfls_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, v;
  logic wreq, mre, mwe, ire, iwe, busy;
  logic [15:0] madr;
  logic [7:0] mwd, mrd, iwd, ird, st, s;
  logic [5:0] iadr;
  logic [31:0] bcnt = 32'h0;
  logic [2:0] fi [8] = '{3'd0, 3'd2, 3'd1, 3'd7, 3'd4, 3'd3, 3'd6, 3'd5};
  int n_fail = 0;
  int cmp_count = 0;
  always #12.5 i_clk = ~i_clk;
  // busy length is judged by counting sampled edges
  always @(posedge i_clk)
    if (busy === 1'b1)
      bcnt <= bcnt + 32'h1;
  cbfls_core uut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .o_mem_addr(madr), .o_mem_re(mre), .o_mem_we(mwe),
    .o_mem_wdata(mwd), .i_mem_rdata(mrd), .o_io_addr(iadr), .o_io_re(ire), .o_io_we(iwe),
    .o_io_wdata(iwd), .i_io_rdata(ird), .o_status(st), .o_busy(busy));
  cbfls_mem_model mdl (.i_clk(i_clk), .i_mem_addr(madr), .i_mem_re(mre), .i_mem_we(mwe),
    .i_mem_wdata(mwd), .o_mem_rdata(mrd), .i_io_addr(iadr), .i_io_re(ire), .i_io_we(iwe),
    .i_io_wdata(iwd), .o_io_rdata(ird));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    @(posedge i_clk);
    while (wreq !== 1'b0)
      @(posedge i_clk);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  task automatic setr(input logic [4:0] i, input logic [7:0] d);
    bus(1'b1, `CB_OFS_SEL, {27'h0, i});
    bus(1'b1, `CB_OFS_GPR, {24'h0, d});
  endtask : setr
  task automatic getr(input logic [4:0] i);
    bus(1'b1, `CB_OFS_SEL, {27'h0, i});
    bus(1'b0, `CB_OFS_GPR, 32'h0);
  endtask : getr
  task automatic stat();
    bus(1'b0, `CB_OFS_STAT, 32'h0);
  endtask : stat
  task automatic run(input logic [5:0] op, input logic [4:0] d, input logic [4:0] r,
                     input logic [2:0] b);
    bcnt = 32'h0;
    bus(1'b1, `CB_OFS_CMD, {5'h0, b, 3'h0, r, 3'h0, d, 2'h0, op});
    v = 32'h100;
    while (v[8] !== 1'b0)
      stat();
  endtask : run
  function automatic logic [12:0] sh(input logic [5:0] op, input logic [7:0] a, input logic c);
    logic [7:0] r;
    logic co;
    case (op)
      6'h01: {co, r} = {a, 1'b0};
      6'h02: {r, co} = {1'b0, a};
      6'h03: {co, r} = {a, c};
      6'h04: {r, co} = {c, a};
      default: {r, co} = {a[7], a};
    endcase
    return {r[7] ^ r[7] ^ co, r[7] ^ co, r[7], r == 8'h00, co, r};
  endfunction : sh
  task automatic t_bus();
    stat();
    check(v, 32'h0);
    getr(5'd31);
    check(v, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    check(v, 32'h0);
    $display("bus test done");
  endtask : t_bus
  task automatic t_shift();
    logic [12:0] e;
    for (int k = 1; k < 6; k++) begin
      for (int j = 0; j < 2; j++) begin
        setr(5'd5, j ? 8'h01 : 8'h81);
        run(k[0] ^ j[0] ? 6'h0b : 6'h0c, 5'd0, 5'd0, 3'd0);
        stat();
        s = v[7:0];
        e = sh(6'(k), j ? 8'h01 : 8'h81, k[0] ^ j[0]);
        run(6'(k), 5'd5, 5'd0, 3'd0);
        check(bcnt, 32'h1);
        stat();
        check(v[7:0], {s[7:5], e[12:8]});
        getr(5'd5);
        check(v[7:0], e[7:0]);
      end
    end
    $display("shift test done");
  endtask : t_shift
  // fixed flag ops first, then the indexed pair on every bit
  task automatic t_flag();
    logic [7:0] m;
    for (int k = 0; k < 32; k++) begin
      stat();
      s = v[7:0];
      m = 8'h01 << (k < 16 ? fi[k / 2] : 3'((k - 16) / 2));
      run(k < 16 ? 6'h0b + 6'(k) : 6'h07 + 6'(k % 2), 5'd0, 5'd0, 3'((k - 16) / 2));
      check(bcnt, 32'h1);
      stat();
      check(v[7:0], k[0] ? s & ~m : s | m);
    end
    $display("flag test done");
  endtask : t_flag
  task automatic t_move();
    setr(5'd5, 8'h08);
    setr(5'd6, 8'h80);
    setr(5'd2, 8'h3c);
    setr(5'd3, 8'h96);
    run(6'h18, 5'd0, 5'd0, 3'd0);
    stat();
    s = v[7:0];
    run(6'h09, 5'd5, 5'd0, 3'd3);
    stat();
    check(v[7:0], s | 8'h40);
    run(6'h0a, 5'd6, 5'd0, 3'd0);
    getr(5'd6);
    check(v[7:0], 8'h81);
    run(6'h09, 5'd5, 5'd0, 3'd2);
    run(6'h0a, 5'd6, 5'd0, 3'd7);
    getr(5'd6);
    check(v[7:0], 8'h01);
    run(6'h06, 5'd2, 5'd0, 3'd0);
    check(bcnt, 32'h1);
    run(6'h1b, 5'd8, 5'd3, 3'd0);
    run(6'h1c, 5'd10, 5'd2, 3'd0);
    bus(1'b1, `CB_OFS_IMM, 32'h5a);
    run(6'h1d, 5'd12, 5'd0, 3'd0);
    check(bcnt, 32'h1);
    for (int i = 0; i < 5; i++) begin
      getr(i == 0 ? 5'd2 : 5'(i + 7 + (i > 1)));
      check(v[7:0], i == 0 || i == 2 ? 8'hc3 : i == 4 ? 8'h5a : 8'h96);
    end
    stat();
    check(v[7:0], s);
    $display("move test done");
  endtask : t_move
  task automatic t_mem();
    stat();
    s = v[7:0];
    bus(1'b1, `CB_OFS_IMM, 32'h12);
    run(6'h1e, 5'd0, 5'd0, 3'd0);
    check(bcnt, 32'h2);
    check(mdl.io[18], 8'h13);
    run(6'h1f, 5'd0, 5'd0, 3'd4);
    check(bcnt, 32'h2);
    check(mdl.io[18], 8'h03);
    setr(5'd26, 8'hff);
    setr(5'd27, 8'h00);
    run(6'h21, 5'd1, 5'd0, 3'd0);
    check(bcnt, 32'h2);
    getr(5'd1);
    check(v[7:0], 8'h5a);
    getr(5'd27);
    check(v[7:0], 8'h01);
    setr(5'd28, 8'h00);
    setr(5'd29, 8'h01);
    run(6'h22, 5'd2, 5'd1, 3'd0);
    check(bcnt, 32'h2);
    getr(5'd2);
    check(v[7:0], 8'h5a);
    getr(5'd29);
    check(v[7:0], 8'h00);
    setr(5'd30, 8'h30);
    setr(5'd31, 8'h00);
    bus(1'b1, `CB_OFS_IMM, 32'h3f);
    run(6'h23, 5'd3, 5'd2, 3'd0);
    check(bcnt, 32'h2);
    getr(5'd3);
    check(v[7:0], 8'h6f ^ 8'ha5);
    bus(1'b1, `CB_OFS_IMM, 32'h44);
    run(6'h24, 5'd4, 5'd0, 3'd0);
    check(bcnt, 32'h2);
    getr(5'd4);
    check(v[7:0], 8'h44 ^ 8'ha5);
    setr(5'd9, 8'h77);
    run(6'h26, 5'd9, 5'd2, 3'd0);
    check(bcnt, 32'h2);
    check(mdl.mem[48], 8'h77);
    run(6'h25, 5'd9, 5'd2, 3'd0);
    check(bcnt, 32'h2);
    check(mdl.mem[49], 8'h77);
    run(6'h20, 5'd7, 5'd2, 3'd0);
    check(bcnt, 32'h2);
    getr(5'd7);
    check(v[7:0], 8'h77);
    getr(5'd30);
    check(v[7:0], 8'h31);
    stat();
    check(v[7:0], s);
    $display("memory test done");
  endtask : t_mem
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // tests need some thousand cycles; forty times that means a hang
  initial begin
    #(40000 * 25);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_bus();
    t_shift();
    t_flag();
    t_move();
    t_mem();
    summarize();
  end
endmodule : cbfls_core_tb

// [test/cbfls_mem_model.sv]
// data memory and io register space model for the core slice
module cbfls_mem_model (
  // clock
  input wire logic i_clk,
  // data memory
  input wire logic [15:0] i_mem_addr,
  input wire logic i_mem_re,
  input wire logic i_mem_we,
  input wire logic [7:0] i_mem_wdata,
  output logic [7:0] o_mem_rdata,
  // io space
  input wire logic [5:0] i_io_addr,
  input wire logic i_io_re,
  input wire logic i_io_we,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] io [64];
  logic [7:0] mlast = 8'h00;
  logic [7:0] ilast = 8'h00;
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'ha5;
    for (int i = 0; i < 64; i++)
      io[i] = 8'(i);
  end
  // released lines show the inverse, so a late sample never looks right
  assign o_mem_rdata = i_mem_re ? mem[i_mem_addr[7:0]] : ~mlast;
  assign o_io_rdata = i_io_re ? io[i_io_addr] : ~ilast;
  always @(posedge i_clk) begin
    if (i_mem_re)
      mlast <= mem[i_mem_addr[7:0]];
    if (i_io_re)
      ilast <= io[i_io_addr];
    if (i_mem_we)
      mem[i_mem_addr[7:0]] <= i_mem_wdata;
    if (i_io_we)
      io[i_io_addr] <= i_io_wdata;
  end
endmodule : cbfls_mem_model

// [verilog/cbfls_consts.svh]
// register offsets, field positions, reset values and cycle counts
`ifndef CBFLS_CONSTS_SVH
`define CBFLS_CONSTS_SVH
// avalon byte offsets
`define CB_OFS_CMD 5'h00
`define CB_OFS_IMM 5'h04
`define CB_OFS_STAT 5'h08
`define CB_OFS_SEL 5'h0c
`define CB_OFS_GPR 5'h10
// command word fields
`define CB_OP_HI 5
`define CB_OP_LO 0
`define CB_RD_HI 12
`define CB_RD_LO 8
`define CB_RR_HI 20
`define CB_RR_LO 16
`define CB_BIT_HI 26
`define CB_BIT_LO 24
// immediate sub-fields
`define CB_DISP_HI 5
`define CB_IOA_HI 5
// status word busy bit
`define CB_STAT_BUSY 8
// status flag positions
`define CB_FC 3'h0
`define CB_FZ 3'h1
`define CB_FN 3'h2
`define CB_FV 3'h3
`define CB_FS 3'h4
`define CB_FH 3'h5
`define CB_FT 3'h6
`define CB_FI 3'h7
// pointer low-byte registers
`define CB_PTR_X 5'h1a
`define CB_PTR_Y 5'h1c
`define CB_PTR_Z 5'h1e
// reset values
`define CB_RST_STATUS_REGISTER 8'h00
`define CB_RST_GPR 8'h00
`define CB_RST_WORD 32'h0000_0000
// execution lengths in cycles
`define CB_CYC_SHORT 1
`define CB_CYC_LONG 2
`endif

// [verilog/cbfls_core.sv]
// core slice: bit, flag, shift, move and load/store execution
//
// The address map and register access over Avalon-MM were left to the implementer.
`include "cbfls_consts.svh"
module cbfls_core (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // data memory
  output logic [15:0] o_mem_addr,
  output logic o_mem_re,
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  // i/o register space
  output logic [5:0] o_io_addr,
  output logic o_io_re,
  output logic o_io_we,
  output logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata,
  // core state
  output logic [7:0] o_status,
  output logic o_busy
);
  localparam int CYC_SHORT = `CB_CYC_SHORT;
  localparam int CYC_LONG = `CB_CYC_LONG;

  cbfls_pkg::cbfls_state_t state_reg, state_next;
  cbfls_pkg::cbfls_op_t op;
  logic [31:0] cmd_reg;
  logic [15:0] imm_reg;
  logic [4:0] sel_reg;
  logic [7:0] status_register_reg;
  logic [7:0] gpr_reg [32];
  logic req, stall, bus_wr;
  logic [31:0] wmask;
  logic [4:0] rd_idx, rr_idx, ptr_lo, pair_d, pair_s;
  logic [2:0] bit_idx, flag_idx;
  logic [7:0] rd_val, rr_val, bit_mask, flag_mask;
  logic [15:0] ptr_val, eff_addr;
  logic is_ld, is_st, is_io, is_sh, flag_hit, flag_val;
  logic in_exec, in_done;
  logic wa_en, wb_en;
  logic [4:0] wa_idx, wb_idx;
  logic [7:0] wa_dat, wb_dat;
  logic [7:0] sh_res;
  logic sh_c, sh_z, sh_n, sh_v, sh_s;

  // bus side
  assign req = i_avs_read | i_avs_write;
  assign bus_wr = i_avs_write & ~o_avs_waitrequest;
  assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                  {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  // a new command or a register poke waits out a running instruction
  assign stall = i_avs_write & o_busy &
                 ((i_avs_address == `CB_OFS_CMD) | (i_avs_address == `CB_OFS_GPR));

  // low for exactly one cycle per accepted request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(req & o_avs_waitrequest & ~stall);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= `CB_RST_WORD;
    end else if (i_avs_read & o_avs_waitrequest) begin
      case (i_avs_address)
        `CB_OFS_CMD: o_avs_readdata <= cmd_reg;
        `CB_OFS_IMM: o_avs_readdata <= {16'h0000, imm_reg};
        `CB_OFS_STAT: o_avs_readdata <= {23'h000000, o_busy, status_register_reg};
        `CB_OFS_SEL: o_avs_readdata <= {27'h0000000, sel_reg};
        `CB_OFS_GPR: o_avs_readdata <= {24'h000000, gpr_reg[sel_reg]};
        default: o_avs_readdata <= `CB_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_reg <= `CB_RST_WORD;
      imm_reg <= 16'(`CB_RST_WORD);
      sel_reg <= 5'(`CB_RST_WORD);
    end else if (bus_wr) begin
      if (i_avs_address == `CB_OFS_CMD) begin
        cmd_reg <= (cmd_reg & ~wmask) | (i_avs_writedata & wmask);
      end
      if (i_avs_address == `CB_OFS_IMM) begin
        imm_reg <= (imm_reg & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
      end
      if (i_avs_address == `CB_OFS_SEL && i_avs_byteenable[0]) begin
        sel_reg <= i_avs_writedata[4:0];
      end
    end
  end

  // decode
  assign op = cbfls_pkg::cbfls_op_t'(cmd_reg[`CB_OP_HI:`CB_OP_LO]);
  assign rd_idx = cmd_reg[`CB_RD_HI:`CB_RD_LO];
  assign rr_idx = cmd_reg[`CB_RR_HI:`CB_RR_LO];
  assign bit_idx = cmd_reg[`CB_BIT_HI:`CB_BIT_LO];
  assign rd_val = gpr_reg[rd_idx];
  assign rr_val = gpr_reg[rr_idx];
  assign bit_mask = 8'h01 << bit_idx;
  assign flag_mask = 8'h01 << flag_idx;
  assign pair_d = {rd_idx[4:1], 1'b0};
  assign pair_s = {rr_idx[4:1], 1'b0};
  assign in_exec = (state_reg == cbfls_pkg::STATE_EXEC);
  assign in_done = (state_reg == cbfls_pkg::STATE_DONE);
  // pointer select 0 x, 1 y, 2 and 3 z
  assign ptr_lo = (rr_idx[1:0] == 2'h0) ? `CB_PTR_X :
                  (rr_idx[1:0] == 2'h1) ? `CB_PTR_Y : `CB_PTR_Z;
  assign ptr_val = {gpr_reg[ptr_lo | 5'h01], gpr_reg[ptr_lo]};

  always_comb begin
    is_ld = op inside {cbfls_pkg::OP_RDP, cbfls_pkg::OP_RDINC, cbfls_pkg::OP_RDDEC,
                       cbfls_pkg::OP_RDDSP, cbfls_pkg::OP_RDABS};
    is_st = op inside {cbfls_pkg::OP_WRP, cbfls_pkg::OP_WRINC};
    is_io = op inside {cbfls_pkg::OP_IOSET, cbfls_pkg::OP_IOCLR};
    is_sh = op inside {cbfls_pkg::OP_SHL, cbfls_pkg::OP_SHR, cbfls_pkg::OP_RCL,
                       cbfls_pkg::OP_RCR, cbfls_pkg::OP_SAR};
    case (op)
      cbfls_pkg::OP_RDDEC: eff_addr = ptr_val - 16'h0001;
      cbfls_pkg::OP_RDDSP: eff_addr = ptr_val + {10'h000, imm_reg[`CB_DISP_HI:0]};
      cbfls_pkg::OP_RDABS: eff_addr = imm_reg;
      default: eff_addr = ptr_val;
    endcase
  end

  // flag set/clear decode, fixed ones map onto the indexed form
  always_comb begin
    flag_hit = 1'b1;
    flag_idx = bit_idx;
    flag_val = 1'b1;
    case (op)
      cbfls_pkg::OP_FSET: flag_val = 1'b1;
      cbfls_pkg::OP_FCLR: flag_val = 1'b0;
      cbfls_pkg::OP_CSET: flag_idx = `CB_FC;
      cbfls_pkg::OP_CCLR: {flag_idx, flag_val} = {`CB_FC, 1'b0};
      cbfls_pkg::OP_NSET: flag_idx = `CB_FN;
      cbfls_pkg::OP_NCLR: {flag_idx, flag_val} = {`CB_FN, 1'b0};
      cbfls_pkg::OP_ZSET: flag_idx = `CB_FZ;
      cbfls_pkg::OP_ZCLR: {flag_idx, flag_val} = {`CB_FZ, 1'b0};
      cbfls_pkg::OP_ISET: flag_idx = `CB_FI;
      cbfls_pkg::OP_ICLR: {flag_idx, flag_val} = {`CB_FI, 1'b0};
      cbfls_pkg::OP_SSET: flag_idx = `CB_FS;
      cbfls_pkg::OP_SCLR: {flag_idx, flag_val} = {`CB_FS, 1'b0};
      cbfls_pkg::OP_VSET: flag_idx = `CB_FV;
      cbfls_pkg::OP_VCLR: {flag_idx, flag_val} = {`CB_FV, 1'b0};
      cbfls_pkg::OP_TSET: flag_idx = `CB_FT;
      cbfls_pkg::OP_TCLR: {flag_idx, flag_val} = {`CB_FT, 1'b0};
      cbfls_pkg::OP_HSET: flag_idx = `CB_FH;
      cbfls_pkg::OP_HCLR: {flag_idx, flag_val} = {`CB_FH, 1'b0};
      default: flag_hit = 1'b0;
    endcase
  end

  cbfls_shift_unit u_shift (
    .i_op(op),
    .i_val(rd_val),
    .i_carry(status_register_reg[`CB_FC]),
    .o_res(sh_res),
    .o_c(sh_c),
    .o_z(sh_z),
    .o_n(sh_n),
    .o_v(sh_v),
    .o_s(sh_s)
  );

  // two register write ports; pointer updates land in the first cycle,
  // loaded data in the second, so three writes never collide
  always_comb begin
    wa_en = 1'b0;
    wa_idx = rd_idx;
    wa_dat = rd_val;
    wb_en = 1'b0;
    wb_idx = ptr_lo | 5'h01;
    wb_dat = ptr_val[15:8];
    if (in_exec) begin
      case (op)
        cbfls_pkg::OP_SHL, cbfls_pkg::OP_SHR, cbfls_pkg::OP_RCL,
        cbfls_pkg::OP_RCR, cbfls_pkg::OP_SAR: begin
          wa_en = 1'b1;
          wa_dat = sh_res;
        end
        cbfls_pkg::OP_NSWAP: begin
          wa_en = 1'b1;
          wa_dat = {rd_val[3:0], rd_val[7:4]};
        end
        cbfls_pkg::OP_T2B: begin
          wa_en = 1'b1;
          wa_dat = status_register_reg[`CB_FT] ? (rd_val | bit_mask) : (rd_val & ~bit_mask);
        end
        cbfls_pkg::OP_CPY: begin
          wa_en = 1'b1;
          wa_dat = rr_val;
        end
        cbfls_pkg::OP_KLD: begin
          wa_en = 1'b1;
          wa_dat = imm_reg[7:0];
        end
        cbfls_pkg::OP_CPYW: begin
          wa_en = 1'b1;
          wa_idx = pair_d;
          wa_dat = gpr_reg[pair_s];
          wb_en = 1'b1;
          wb_idx = pair_d | 5'h01;
          wb_dat = gpr_reg[pair_s | 5'h01];
        end
        cbfls_pkg::OP_RDINC, cbfls_pkg::OP_WRINC, cbfls_pkg::OP_RDDEC: begin
          wa_en = 1'b1;
          wb_en = 1'b1;
          wa_idx = ptr_lo;
          {wb_dat, wa_dat} = (op == cbfls_pkg::OP_RDDEC) ? eff_addr : ptr_val + 16'h0001;
        end
        default: wa_en = 1'b0;
      endcase
    end else if (in_done && is_ld) begin
      wa_en = 1'b1;
      wa_dat = i_mem_rdata;
    end else if (bus_wr && i_avs_address == `CB_OFS_GPR && i_avs_byteenable[0]) begin
      wa_en = 1'b1;
      wa_idx = sel_reg;
      wa_dat = i_avs_writedata[7:0];
    end
  end

  for (genvar gi = 0; gi < 32; gi++) begin : g_gpr
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        gpr_reg[gi] <= `CB_RST_GPR;
      end else if (wa_en && wa_idx == 5'(gi)) begin
        gpr_reg[gi] <= wa_dat;
      end else if (wb_en && wb_idx == 5'(gi)) begin
        gpr_reg[gi] <= wb_dat;
      end
    end
  end

  // sequencing: one-cycle ops finish in exec, memory and io ops add done
  always_comb begin
    case (state_reg)
      cbfls_pkg::STATE_IDLE:
        state_next = (bus_wr && i_avs_address == `CB_OFS_CMD) ?
                     cbfls_pkg::STATE_EXEC : cbfls_pkg::STATE_IDLE;
      cbfls_pkg::STATE_EXEC:
        state_next = (is_ld | is_st | is_io) ? cbfls_pkg::STATE_DONE : cbfls_pkg::STATE_IDLE;
      default: state_next = cbfls_pkg::STATE_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= cbfls_pkg::STATE_IDLE;
      o_busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      o_busy <= (state_next != cbfls_pkg::STATE_IDLE);
    end
  end

  // status flags
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_register_reg <= `CB_RST_STATUS_REGISTER;
    end else if (in_exec && is_sh) begin
      status_register_reg[`CB_FC] <= sh_c;
      status_register_reg[`CB_FZ] <= sh_z;
      status_register_reg[`CB_FN] <= sh_n;
      status_register_reg[`CB_FV] <= sh_v;
      status_register_reg[`CB_FS] <= sh_s;
    end else if (in_exec && op == cbfls_pkg::OP_B2T) begin
      status_register_reg[`CB_FT] <= rd_val[bit_idx];
    end else if (in_exec && flag_hit) begin
      status_register_reg[flag_idx] <= flag_val;
    end
  end
  assign o_status = status_register_reg;

  // data memory strobes, one cycle each, read data taken in done
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_re <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 16'(`CB_RST_WORD);
      o_mem_wdata <= `CB_RST_GPR;
    end else begin
      o_mem_re <= in_exec & is_ld;
      o_mem_we <= in_exec & is_st;
      if (in_exec && (is_ld || is_st)) begin
        o_mem_addr <= eff_addr;
      end
      if (in_exec && is_st) begin
        o_mem_wdata <= rd_val;
      end
    end
  end

  // io read in done, modified write in the cycle after done
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_io_re <= 1'b0;
      o_io_we <= 1'b0;
      o_io_addr <= 6'(`CB_RST_WORD);
      o_io_wdata <= `CB_RST_GPR;
    end else begin
      o_io_re <= in_exec & is_io;
      o_io_we <= in_done & is_io;
      if (in_exec && is_io) begin
        o_io_addr <= imm_reg[`CB_IOA_HI:0];
      end
      if (in_done && is_io) begin
        o_io_wdata <= (op == cbfls_pkg::OP_IOSET) ? (i_io_rdata | bit_mask) :
                      (i_io_rdata & ~bit_mask);
      end
    end
  end

  // checks
  default clocking cb_clk @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_IO_SET: assert property (
    in_done && op == cbfls_pkg::OP_IOSET |=> o_io_we && $stable(status_register_reg) &&
      o_io_wdata == ($past(i_io_rdata) | $past(bit_mask)))
    else $error("io bit set wrote wrong value");
  AST_IO_CLR: assert property (
    in_exec && op == cbfls_pkg::OP_IOCLR |=> o_io_re ##1 o_io_we && !o_busy &&
      o_io_wdata == ($past(i_io_rdata) & ~$past(bit_mask)))
    else $error("io bit clear wrong value or timing");
  AST_SHL: assert property (
    in_exec && op == cbfls_pkg::OP_SHL |=> !o_busy && status_register_reg[`CB_FC] == $past(rd_val[7])
      && gpr_reg[$past(rd_idx)] == {$past(rd_val[6:0]), 1'b0})
    else $error("shift left result wrong");
  AST_SHR: assert property (
    in_exec && op == cbfls_pkg::OP_SHR |=> !status_register_reg[`CB_FN] &&
      gpr_reg[$past(rd_idx)] == {1'b0, $past(rd_val[7:1])})
    else $error("shift right result wrong");
  AST_RCL: assert property (
    in_exec && op == cbfls_pkg::OP_RCL |=> status_register_reg[`CB_FC] == $past(rd_val[7]) &&
      gpr_reg[$past(rd_idx)] == {$past(rd_val[6:0]), $past(status_register_reg[0])})
    else $error("rotate left result wrong");
  AST_RCR: assert property (
    in_exec && op == cbfls_pkg::OP_RCR |=> status_register_reg[`CB_FC] == $past(rd_val[0]) &&
      gpr_reg[$past(rd_idx)] == {$past(status_register_reg[0]), $past(rd_val[7:1])})
    else $error("rotate right result wrong");
  AST_SAR: assert property (
    in_exec && op == cbfls_pkg::OP_SAR |=> gpr_reg[$past(rd_idx)][7] == $past(rd_val[7])
      && status_register_reg[`CB_FZ] == (gpr_reg[$past(rd_idx)] == 8'h00))
    else $error("arithmetic shift wrong");
  AST_B2T: assert property (
    in_exec && op == cbfls_pkg::OP_B2T |=> status_register_reg[`CB_FT] == $past(rd_val[bit_idx])
      && status_register_reg[5:0] == $past(status_register_reg[5:0]) && status_register_reg[7] == $past(status_register_reg[7]))
    else $error("bit to t wrong");
  AST_T2B: assert property (
    in_exec && op == cbfls_pkg::OP_T2B |=> $stable(status_register_reg) &&
      gpr_reg[$past(rd_idx)][$past(bit_idx)] == status_register_reg[`CB_FT])
    else $error("t to bit wrong");
  AST_FLAG: assert property (
    in_exec && flag_hit |=> status_register_reg == ($past(flag_val) ?
      ($past(status_register_reg) | $past(flag_mask)) : ($past(status_register_reg) & ~$past(flag_mask))))
    else $error("flag op touched wrong flag");
  AST_LD_INC: assert property (
    in_exec && op == cbfls_pkg::OP_RDINC |=> o_mem_re && o_mem_addr == $past(ptr_val)
      && ptr_val == 16'($past(ptr_val) + 16'h0001))
    else $error("post-increment load wrong");
  AST_LD_DEC: assert property (
    in_exec && op == cbfls_pkg::OP_RDDEC |=> o_mem_re && o_mem_addr == ptr_val &&
      ptr_val == 16'($past(ptr_val) - 16'h0001))
    else $error("pre-decrement load wrong");
  AST_LD_DSP: assert property (
    in_exec && op == cbfls_pkg::OP_RDDSP |=> $stable(ptr_val) &&
      o_mem_addr == 16'($past(ptr_val) + $past(imm_reg[`CB_DISP_HI:0])))
    else $error("displaced load address wrong");
  AST_LD_DATA: assert property (
    in_done && is_ld |=> !o_busy && $stable(status_register_reg) &&
      gpr_reg[$past(rd_idx)] == $past(i_mem_rdata))
    else $error("loaded data not written");
  AST_ST_INC: assert property (
    in_exec && op == cbfls_pkg::OP_WRINC |=> o_mem_we && o_mem_wdata == $past(rd_val)
      && o_mem_addr == $past(ptr_val) ##1 !o_mem_we && !o_busy)
    else $error("post-increment store wrong");
  AST_LONG: assert property (
    in_exec && (is_ld || is_st || is_io) |-> o_busy ##CYC_LONG !o_busy)
    else $error("two-cycle op wrong length");
  AST_SHORT: assert property (
    in_exec && !(is_ld || is_st || is_io) |-> ##CYC_SHORT !o_busy)
    else $error("one-cycle op wrong length");
  AST_SWAP: assert property (
    in_exec && op == cbfls_pkg::OP_NSWAP |=> $stable(status_register_reg) &&
      gpr_reg[$past(rd_idx)] == {$past(rd_val[3:0]), $past(rd_val[7:4])})
    else $error("nibble swap wrong");

  CVR_IO: cover property (in_exec && is_io ##2 o_io_we);
  CVR_LD: cover property (in_done && op == cbfls_pkg::OP_RDDEC);
  CVR_ST: cover property (o_mem_we && $past(op == cbfls_pkg::OP_WRINC));
  CVR_STALL: cover property (stall ##1 stall);
endmodule : cbfls_core

// [verilog/cbfls_pkg.sv]
// operation codes and state type
package cbfls_pkg;
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_SHL = 6'h01, OP_SHR = 6'h02, OP_RCL = 6'h03,
    OP_RCR = 6'h04, OP_SAR = 6'h05, OP_NSWAP = 6'h06, OP_FSET = 6'h07,
    OP_FCLR = 6'h08, OP_B2T = 6'h09, OP_T2B = 6'h0a, OP_CSET = 6'h0b,
    OP_CCLR = 6'h0c, OP_NSET = 6'h0d, OP_NCLR = 6'h0e, OP_ZSET = 6'h0f,
    OP_ZCLR = 6'h10, OP_ISET = 6'h11, OP_ICLR = 6'h12, OP_SSET = 6'h13,
    OP_SCLR = 6'h14, OP_VSET = 6'h15, OP_VCLR = 6'h16, OP_TSET = 6'h17,
    OP_TCLR = 6'h18, OP_HSET = 6'h19, OP_HCLR = 6'h1a, OP_CPY = 6'h1b,
    OP_CPYW = 6'h1c, OP_KLD = 6'h1d, OP_IOSET = 6'h1e, OP_IOCLR = 6'h1f,
    OP_RDP = 6'h20, OP_RDINC = 6'h21, OP_RDDEC = 6'h22, OP_RDDSP = 6'h23,
    OP_RDABS = 6'h24, OP_WRP = 6'h25, OP_WRINC = 6'h26
  } cbfls_op_t;
  typedef enum logic [1:0] {
    STATE_IDLE = 2'b00,
    STATE_EXEC = 2'b01,
    STATE_DONE = 2'b10
  } cbfls_state_t;
endpackage : cbfls_pkg

// [verilog/cbfls_shift_unit.sv]
// shift and rotate datapath with flag results
module cbfls_shift_unit (
  // operation and operand
  input wire cbfls_pkg::cbfls_op_t i_op,
  input wire logic [7:0] i_val,
  input wire logic i_carry,
  // result and flags
  output logic [7:0] o_res,
  output logic o_c,
  output logic o_z,
  output logic o_n,
  output logic o_v,
  output logic o_s
);
  always_comb begin
    o_res = i_val;
    o_c = i_carry;
    case (i_op)
      cbfls_pkg::OP_SHL: begin
        o_res = {i_val[6:0], 1'b0};
        o_c = i_val[7];
      end
      cbfls_pkg::OP_SHR: begin
        o_res = {1'b0, i_val[7:1]};
        o_c = i_val[0];
      end
      cbfls_pkg::OP_RCL: begin
        o_res = {i_val[6:0], i_carry};
        o_c = i_val[7];
      end
      cbfls_pkg::OP_RCR: begin
        o_res = {i_carry, i_val[7:1]};
        o_c = i_val[0];
      end
      cbfls_pkg::OP_SAR: begin
        o_res = {i_val[7], i_val[7:1]};
        o_c = i_val[0];
      end
      default: begin
        o_res = i_val;
        o_c = i_carry;
      end
    endcase
    o_z = (o_res == 8'h00);
    o_n = o_res[7];
    // overflow from sign and carry, as for any shift
    o_v = o_n ^ o_c;
    o_s = o_n ^ o_v;
  end
endmodule : cbfls_shift_unit
